// file: pkg/plc_consts.svh
// Offsets, field positions, reset values and sizes of the PLL power-down control registers
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH

// Bus shape
`define PLC_ADDR_W 16
`define PLC_DATA_W 8

// Register byte addresses
`define PLC_A_LOCK_CTL 16'h0069
`define PLC_A_OSC_VAL 16'h006a
`define PLC_A_PUMP 16'h006c
`define PLC_A_REF_OFF 16'h006d
`define PLC_A_ALARM_DBL 16'h006e
`define PLC_A_PAIR_OFF 16'h006f
`define PLC_A_BLOCK_OFF 16'h0070
`define PLC_A_IRQ_STS 16'h0080
`define PLC_A_IRQ_MSK 16'h0081
`define PLC_A_LIVE 16'h0082

// Field positions
`define PLC_B_OVERRIDE 0
`define PLC_F_OSC_SEL 7:5
`define PLC_F_LOCK_VAL 4:0
`define PLC_F_PUMP 4:0
`define PLC_F_REF_OFF 1:0
`define PLC_B_POLICY 1
`define PLC_B_DBL_OFF 0
`define PLC_F_PAIR_OFF 3:0
`define PLC_B_DPLL_OFF 2
`define PLC_B_DSM_OFF 1
`define PLC_B_CAL_HOLD 0
`define PLC_B_LOL 0
`define PLC_B_LIVE_ALARM 0
`define PLC_B_LIVE_LOCKED 1
`define PLC_B_LIVE_STABLE 2

// Field widths and counts
`define PLC_OSC_W 3
`define PLC_VAL_W 5
`define PLC_PUMP_W 5
`define PLC_REFS 2
`define PLC_PAIRS 4
`define PLC_SYNC_W 2

// Codes and reset values
`define PLC_OSC_VCO0 3'h0
`define PLC_OSC_VCO1 3'h1
`define PLC_RST_OSC 3'h1
`define PLC_RST_VAL 5'h0b
`define PLC_RST_PUMP 5'h00

`endif

// file: pkg/plc_pkg.sv
// State types of the PLL power-down control block
`include "plc_consts.svh"
package plc_pkg;

	// Three-stage pin synchroniser state
	typedef struct packed {
		logic [`PLC_SYNC_W-1:0] ff1;
		logic [`PLC_SYNC_W-1:0] ff2;
		logic [`PLC_SYNC_W-1:0] ff3;
		logic [`PLC_SYNC_W-1:0] q;
	} plc_sync_st_t;

	// Loss-of-lock alarm state
	typedef struct packed {
		logic alarm;
		logic rise;
	} plc_lol_st_t;

	// Register file and output state
	typedef struct packed {
		logic override;
		logic [`PLC_OSC_W-1:0] osc_sel;
		logic [`PLC_VAL_W-1:0] lock_val;
		logic [`PLC_VAL_W-1:0] lock_apply;
		logic [`PLC_PUMP_W-1:0] pump;
		logic [`PLC_REFS-1:0] ref_off;
		logic policy;
		logic dbl_off;
		logic [`PLC_PAIRS-1:0] pair_off;
		logic dpll_off;
		logic dsm_off;
		logic cal_hold;
		logic sts;
		logic msk;
		logic irq;
		logic [`PLC_DATA_W-1:0] rdata;
	} plc_top_st_t;

endpackage : plc_pkg

// file: rtl/plc_lol.sv
// Loss-of-lock alarm with selectable release policy
`timescale 1ns/1ps
module plc_lol
	import plc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_locked,
	input wire logic i_stable,
	input wire logic i_policy,
	output logic o_alarm,
	output logic o_rise
);

	plc_lol_st_t st_reg;
	plc_lol_st_t st_next;

	// Alarm raises on loss at once; release waits on policy
	always_comb
	begin
		st_next = st_reg;
		if (i_policy)
			st_next.alarm = !(i_locked && i_stable);
		else
			st_next.alarm = !i_locked;
		st_next.rise = st_next.alarm && !st_reg.alarm;
	end

	// Alarm asserted out of reset until lock is seen
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			st_reg <= '{alarm: 1'b1, rise: 1'b0};
		else
			st_reg <= st_next;
	end

	assign o_alarm = st_reg.alarm;
	assign o_rise = st_reg.rise;

	AST_POLICY_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_policy && i_locked && !i_stable) |=> o_alarm)
		else $error("alarm released before outputs stable");

	AST_RELEASE: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_policy && i_locked) |=> !o_alarm)
		else $error("alarm not released on lock");

endmodule : plc_lol

// file: rtl/plc_sync.sv
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "plc_consts.svh"
module plc_sync
	import plc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [`PLC_SYNC_W-1:0] i_pin,
	output logic [`PLC_SYNC_W-1:0] o_level
);

	plc_sync_st_t st_reg;
	plc_sync_st_t st_next;

	// Output follows only once second and third stage agree
	always_comb
	begin
		st_next = st_reg;
		st_next.ff1 = i_pin;
		st_next.ff2 = st_reg.ff1;
		st_next.ff3 = st_reg.ff2;
		st_next.q = (st_reg.ff2 & st_reg.ff3) | (st_reg.q & (st_reg.ff2 | st_reg.ff3));
	end

	// State register
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_level = st_reg.q;

endmodule : plc_sync

// file: rtl/plc_top.sv
// PLL lock control and power-down register bank with loss-of-lock interrupt
`timescale 1ns/1ps
`include "plc_consts.svh"
module plc_top
	import plc_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic [`PLC_ADDR_W-1:0] I_ADDR,
	input wire logic [`PLC_DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [`PLC_DATA_W-1:0] O_RDATA,
	input wire logic I_PLL_LOCKED,
	input wire logic I_OUT_STABLE,
	output logic O_MANUAL_LOCK,
	output logic [`PLC_OSC_W-1:0] O_OSC_SEL,
	output logic [`PLC_VAL_W-1:0] O_LOCK_VALUE,
	output logic [`PLC_PUMP_W-1:0] O_PUMP_CODE,
	output logic [`PLC_REFS-1:0] O_INPUT_REF_OFF,
	output logic O_CRYSTAL_DOUBLER_OFF,
	output logic [`PLC_PAIRS-1:0] O_OUTPUT_PAIR_OFF,
	output logic O_DIGITAL_LOOP_OFF,
	output logic O_MODULATOR_OFF,
	output logic O_CALIBRATION_HOLD,
	output logic O_LOSS_OF_LOCK_ALARM,
	output logic O_IRQ
);

	plc_top_st_t st_reg;
	plc_top_st_t st_next;
	logic [`PLC_SYNC_W-1:0] pins_sync;
	logic lol_rise;
	logic sts_clear;

	// Reset image of the whole register file
	localparam plc_top_st_t ST_RESET = '{
		override: 1'b0,
		osc_sel: `PLC_RST_OSC,
		lock_val: `PLC_RST_VAL,
		lock_apply: '0,
		pump: `PLC_RST_PUMP,
		ref_off: '0,
		policy: 1'b0,
		dbl_off: 1'b0,
		pair_off: '0,
		dpll_off: 1'b0,
		dsm_off: 1'b0,
		cal_hold: 1'b0,
		sts: 1'b0,
		msk: 1'b0,
		irq: 1'b0,
		rdata: '0
	};

	// True on a write strobe to the given address
	function automatic logic wr_hit(input logic wr, input logic [`PLC_ADDR_W-1:0] a,
		input logic [`PLC_ADDR_W-1:0] target);
		return wr && (a == target);
	endfunction : wr_hit

	// Only the two documented oscillator codes are accepted
	function automatic logic osc_legal(input logic [`PLC_OSC_W-1:0] code);
		return (code == `PLC_OSC_VCO0) || (code == `PLC_OSC_VCO1);
	endfunction : osc_legal

	// Read view; reserved bits and unmapped addresses read zero
	function automatic logic [`PLC_DATA_W-1:0] read_view(input plc_top_st_t s,
		input logic [`PLC_ADDR_W-1:0] a, input logic alarm,
		input logic [`PLC_SYNC_W-1:0] pins);
		logic [`PLC_DATA_W-1:0] d;
		d = '0;
		case (a)
			`PLC_A_LOCK_CTL: d[`PLC_B_OVERRIDE] = s.override;
			`PLC_A_OSC_VAL:
			begin
				d[`PLC_F_OSC_SEL] = s.osc_sel;
				d[`PLC_F_LOCK_VAL] = s.lock_val;
			end
			`PLC_A_PUMP: d[`PLC_F_PUMP] = s.pump;
			`PLC_A_REF_OFF: d[`PLC_F_REF_OFF] = s.ref_off;
			`PLC_A_ALARM_DBL:
			begin
				d[`PLC_B_POLICY] = s.policy;
				d[`PLC_B_DBL_OFF] = s.dbl_off;
			end
			`PLC_A_PAIR_OFF: d[`PLC_F_PAIR_OFF] = s.pair_off;
			`PLC_A_BLOCK_OFF:
			begin
				d[`PLC_B_DPLL_OFF] = s.dpll_off;
				d[`PLC_B_DSM_OFF] = s.dsm_off;
				d[`PLC_B_CAL_HOLD] = s.cal_hold;
			end
			`PLC_A_IRQ_STS: d[`PLC_B_LOL] = s.sts;
			`PLC_A_IRQ_MSK: d[`PLC_B_LOL] = s.msk;
			`PLC_A_LIVE:
			begin
				d[`PLC_B_LIVE_ALARM] = alarm;
				d[`PLC_B_LIVE_LOCKED] = pins[0];
				d[`PLC_B_LIVE_STABLE] = pins[1];
			end
			default: d = '0;
		endcase
		return d;
	endfunction : read_view

	// Lock and stable pins come from the analog side
	plc_sync u_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_pin({I_OUT_STABLE, I_PLL_LOCKED}),
		.o_level(pins_sync)
	);

	// Alarm release follows the policy bit
	plc_lol u_lol (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_locked(pins_sync[0]),
		.i_stable(pins_sync[1]),
		.i_policy(st_reg.policy),
		.o_alarm(O_LOSS_OF_LOCK_ALARM),
		.o_rise(lol_rise)
	);

	assign sts_clear = wr_hit(I_WR, I_ADDR, `PLC_A_IRQ_STS) && I_WDATA[`PLC_B_LOL];

	// Register writes, sticky status, read data and derived outputs
	always_comb
	begin
		st_next = st_reg;
		st_next.rdata = '0;
		if (wr_hit(I_WR, I_ADDR, `PLC_A_LOCK_CTL))
			st_next.override = I_WDATA[`PLC_B_OVERRIDE];
		if (wr_hit(I_WR, I_ADDR, `PLC_A_OSC_VAL))
		begin
			// Reserved codes would steer a missing oscillator, so they are dropped
			if (osc_legal(I_WDATA[`PLC_F_OSC_SEL]))
				st_next.osc_sel = I_WDATA[`PLC_F_OSC_SEL];
			st_next.lock_val = I_WDATA[`PLC_F_LOCK_VAL];
		end
		if (wr_hit(I_WR, I_ADDR, `PLC_A_PUMP))
			st_next.pump = I_WDATA[`PLC_F_PUMP];
		if (wr_hit(I_WR, I_ADDR, `PLC_A_REF_OFF))
			st_next.ref_off = I_WDATA[`PLC_F_REF_OFF];
		if (wr_hit(I_WR, I_ADDR, `PLC_A_ALARM_DBL))
		begin
			st_next.policy = I_WDATA[`PLC_B_POLICY];
			st_next.dbl_off = I_WDATA[`PLC_B_DBL_OFF];
		end
		if (wr_hit(I_WR, I_ADDR, `PLC_A_PAIR_OFF))
			st_next.pair_off = I_WDATA[`PLC_F_PAIR_OFF];
		if (wr_hit(I_WR, I_ADDR, `PLC_A_BLOCK_OFF))
		begin
			st_next.dpll_off = I_WDATA[`PLC_B_DPLL_OFF];
			st_next.dsm_off = I_WDATA[`PLC_B_DSM_OFF];
			st_next.cal_hold = I_WDATA[`PLC_B_CAL_HOLD];
		end
		if (wr_hit(I_WR, I_ADDR, `PLC_A_IRQ_MSK))
			st_next.msk = I_WDATA[`PLC_B_LOL];
		// A new alarm in the clearing cycle is kept: set beats clear
		st_next.sts = (st_reg.sts && !sts_clear) || lol_rise;
		st_next.irq = st_next.sts && st_next.msk;
		// Manual value reaches the oscillator only in manual mode
		st_next.lock_apply = st_next.override ? st_next.lock_val : '0;
		if (I_RD)
			st_next.rdata = read_view(st_reg, I_ADDR, O_LOSS_OF_LOCK_ALARM, pins_sync);
	end

	// State register
	always_ff @(posedge I_CORE_CLK or posedge I_RST)
	begin
		if (I_RST)
			st_reg <= ST_RESET;
		else
			st_reg <= st_next;
	end

	// Outputs straight from the state register
	assign O_RDATA = st_reg.rdata;
	assign O_MANUAL_LOCK = st_reg.override;
	assign O_OSC_SEL = st_reg.osc_sel;
	assign O_LOCK_VALUE = st_reg.lock_apply;
	assign O_PUMP_CODE = st_reg.pump;
	assign O_INPUT_REF_OFF = st_reg.ref_off;
	assign O_CRYSTAL_DOUBLER_OFF = st_reg.dbl_off;
	assign O_OUTPUT_PAIR_OFF = st_reg.pair_off;
	assign O_DIGITAL_LOOP_OFF = st_reg.dpll_off;
	assign O_MODULATOR_OFF = st_reg.dsm_off;
	assign O_CALIBRATION_HOLD = st_reg.cal_hold;
	assign O_IRQ = st_reg.irq;

	// Checks on the register file
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RST);

	AST_OVERRIDE_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_LOCK_CTL)
		|=> O_MANUAL_LOCK == $past(I_WDATA[`PLC_B_OVERRIDE]))
		else $error("override bit did not take written value");

	AST_OSC_LEGAL: assert property (
		O_OSC_SEL == `PLC_OSC_VCO0 || O_OSC_SEL == `PLC_OSC_VCO1)
		else $error("oscillator select holds a reserved code");

	AST_OSC_KEEP: assert property (
		(wr_hit(I_WR, I_ADDR, `PLC_A_OSC_VAL) && !osc_legal(I_WDATA[`PLC_F_OSC_SEL]))
		|=> $stable(O_OSC_SEL))
		else $error("reserved oscillator code was accepted");

	AST_VALUE_APPLY: assert property (
		(wr_hit(I_WR, I_ADDR, `PLC_A_OSC_VAL) && O_MANUAL_LOCK && !I_RD)
		|=> O_LOCK_VALUE == $past(I_WDATA[`PLC_F_LOCK_VAL]))
		else $error("manual lock value not applied");

	AST_VALUE_AUTO: assert property (
		!O_MANUAL_LOCK |-> O_LOCK_VALUE == '0)
		else $error("lock value driven in automatic mode");

	AST_PUMP_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_PUMP) |=> O_PUMP_CODE == $past(I_WDATA[`PLC_F_PUMP]))
		else $error("pump code did not take written value");

	AST_REF_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_REF_OFF)
		|=> O_INPUT_REF_OFF == $past(I_WDATA[`PLC_F_REF_OFF]))
		else $error("reference disables did not update");

	AST_DBL_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_ALARM_DBL)
		|=> O_CRYSTAL_DOUBLER_OFF == $past(I_WDATA[`PLC_B_DBL_OFF]))
		else $error("doubler bit did not update");

	AST_PAIR_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_PAIR_OFF)
		|=> O_OUTPUT_PAIR_OFF == $past(I_WDATA[`PLC_F_PAIR_OFF]))
		else $error("output pair disables did not update");

	AST_BLOCK_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_BLOCK_OFF)
		|=> {O_DIGITAL_LOOP_OFF, O_MODULATOR_OFF, O_CALIBRATION_HOLD}
			== $past(I_WDATA[`PLC_B_DPLL_OFF:`PLC_B_CAL_HOLD]))
		else $error("power-down bits did not update");

	AST_BLOCK_HOLD: assert property (
		!wr_hit(I_WR, I_ADDR, `PLC_A_BLOCK_OFF)
		|=> $stable({O_DIGITAL_LOOP_OFF, O_MODULATOR_OFF, O_CALIBRATION_HOLD}))
		else $error("power-down bits changed without a write");

	AST_STICKY_SET: assert property (
		$rose(O_LOSS_OF_LOCK_ALARM) |=> st_reg.sts)
		else $error("alarm did not set sticky status");

	AST_STICKY_HOLD: assert property (
		(st_reg.sts && !sts_clear) |=> st_reg.sts)
		else $error("sticky status lost without a clear");

	AST_IRQ_LEVEL: assert property (
		(st_reg.sts && st_reg.msk && !sts_clear && !wr_hit(I_WR, I_ADDR, `PLC_A_IRQ_MSK))
		|=> O_IRQ)
		else $error("interrupt not raised for unmasked status");

	AST_RD_IDLE: assert property (
		!I_RD |=> O_RDATA == '0)
		else $error("read data present without a read");

	// Field checks; a legal code must land, not only a reserved one be dropped
	AST_OSC_WR: assert property (
		(wr_hit(I_WR, I_ADDR, `PLC_A_OSC_VAL) && osc_legal(I_WDATA[`PLC_F_OSC_SEL]))
		|=> O_OSC_SEL == $past(I_WDATA[`PLC_F_OSC_SEL]))
		else $error("legal oscillator code was not taken");

	AST_RD_PUMP: assert property (
		(I_RD && I_ADDR == `PLC_A_PUMP)
		|=> O_RDATA[`PLC_F_PUMP] == $past(O_PUMP_CODE))
		else $error("pump code read back wrong");

	AST_PAIR_HOLD: assert property (
		!wr_hit(I_WR, I_ADDR, `PLC_A_PAIR_OFF)
		|=> $stable(O_OUTPUT_PAIR_OFF))
		else $error("output pair disables changed without a write");

	AST_MODULATOR_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_BLOCK_OFF)
		|=> O_MODULATOR_OFF == $past(I_WDATA[`PLC_B_DSM_OFF]))
		else $error("modulator bit did not update");

	AST_CAL_WR: assert property (
		wr_hit(I_WR, I_ADDR, `PLC_A_BLOCK_OFF)
		|=> O_CALIBRATION_HOLD == $past(I_WDATA[`PLC_B_CAL_HOLD]))
		else $error("calibration hold bit did not update");

	// Clear works only when no new alarm edge arrives in the same cycle
	AST_STICKY_CLEAR: assert property (
		(st_reg.sts && sts_clear && !lol_rise)
		|=> !st_reg.sts)
		else $error("sticky status not cleared by write of one");

	AST_IRQ_MASKED: assert property (
		(!st_reg.msk && !wr_hit(I_WR, I_ADDR, `PLC_A_IRQ_MSK))
		|=> !O_IRQ)
		else $error("interrupt raised while masked");

	AST_IRQ_NO_STATUS: assert property (
		(!st_reg.sts && !lol_rise)
		|=> !O_IRQ)
		else $error("interrupt raised without status");

endmodule : plc_top

// file: sim/plc_top_tb.sv
// Self-checking bench for the PLL power-down control register bank
`timescale 1ns/1ps
`include "plc_consts.svh"
module plc_top_tb
	import plc_pkg::*;
;
	logic clk;
	logic rst;
	logic [`PLC_ADDR_W-1:0] addr;
	logic [`PLC_DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic locked;
	logic stable;
	logic [`PLC_DATA_W-1:0] rdata;
	logic manual;
	logic [`PLC_OSC_W-1:0] osc;
	logic [`PLC_VAL_W-1:0] lval;
	logic [`PLC_PUMP_W-1:0] pump;
	logic [`PLC_REFS-1:0] refoff;
	logic dbl;
	logic [`PLC_PAIRS-1:0] pairs;
	logic dpll;
	logic delta_sigma_modulator;
	logic cal;
	logic alarm;
	logic irq;
	int fail_count;
	int compares;

	plc_top u_plc_top (
		.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .I_PLL_LOCKED(locked), .I_OUT_STABLE(stable),
		.O_MANUAL_LOCK(manual), .O_OSC_SEL(osc), .O_LOCK_VALUE(lval), .O_PUMP_CODE(pump),
		.O_INPUT_REF_OFF(refoff), .O_CRYSTAL_DOUBLER_OFF(dbl), .O_OUTPUT_PAIR_OFF(pairs),
		.O_DIGITAL_LOOP_OFF(dpll), .O_MODULATOR_OFF(delta_sigma_modulator), .O_CALIBRATION_HOLD(cal),
		.O_LOSS_OF_LOCK_ALARM(alarm), .O_IRQ(irq)
	);

	// 200 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One-cycle write strobe; outputs settle just after the taking edge
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
		#1;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_chk

	// Sync chain plus alarm register need at most five cycles
	task automatic settle();
		repeat (8) @(posedge clk);
		#1;
	endtask : settle

	task automatic t_reset_values();
		chk({7'h0, manual}, 8'h00);
		chk({5'h0, osc}, 8'h01);
		chk({3'h0, pump}, 8'h00);
		chk({pairs, refoff, dbl, dpll}, 8'h00);
		chk({5'h0, delta_sigma_modulator, cal, alarm}, 8'h01);
		rd_chk(`PLC_A_OSC_VAL, 8'h2b);
		rd_chk(`PLC_A_ALARM_DBL, 8'h00);
		rd_chk(`PLC_A_BLOCK_OFF, 8'h00);
	endtask : t_reset_values

	task automatic t_manual_lock();
		wr_reg(`PLC_A_OSC_VAL, 8'h13);
		chk({3'h0, lval}, 8'h00);
		wr_reg(`PLC_A_LOCK_CTL, 8'h01);
		chk({7'h0, manual}, 8'h01);
		chk({3'h0, lval}, 8'h13);
		chk({5'h0, osc}, 8'h00);
		// Reserved code dropped while lock value still taken
		wr_reg(`PLC_A_OSC_VAL, 8'h4c);
		chk({5'h0, osc}, 8'h00);
		chk({3'h0, lval}, 8'h0c);
		wr_reg(`PLC_A_OSC_VAL, 8'h2b);
		chk({5'h0, osc}, 8'h01);
		wr_reg(`PLC_A_LOCK_CTL, 8'h00);
		chk({7'h0, manual}, 8'h00);
		chk({3'h0, lval}, 8'h00);
	endtask : t_manual_lock

	// Band edges of the pump code table
	task automatic t_pump();
		logic [4:0] codes [6];
		codes = '{5'h00, 5'h0f, 5'h10, 5'h17, 5'h18, 5'h1f};
		foreach (codes[i])
		begin
			wr_reg(`PLC_A_PUMP, {3'h0, codes[i]});
			chk({3'h0, pump}, {3'h0, codes[i]});
			rd_chk(`PLC_A_PUMP, {3'h0, codes[i]});
		end
	endtask : t_pump

	task automatic t_power_down();
		wr_reg(`PLC_A_REF_OFF, 8'h02);
		chk({6'h0, refoff}, 8'h02);
		wr_reg(`PLC_A_REF_OFF, 8'h01);
		chk({6'h0, refoff}, 8'h01);
		wr_reg(`PLC_A_ALARM_DBL, 8'h01);
		chk({7'h0, dbl}, 8'h01);
		wr_reg(`PLC_A_PAIR_OFF, 8'h0a);
		chk({4'h0, pairs}, 8'h0a);
		wr_reg(`PLC_A_PAIR_OFF, 8'h05);
		chk({4'h0, pairs}, 8'h05);
		wr_reg(`PLC_A_BLOCK_OFF, 8'h05);
		chk({5'h0, dpll, delta_sigma_modulator, cal}, 8'h05);
		wr_reg(`PLC_A_BLOCK_OFF, 8'h02);
		chk({5'h0, dpll, delta_sigma_modulator, cal}, 8'h02);
		// All four pair disables set and read back as written
		wr_reg(`PLC_A_PAIR_OFF, 8'h0f);
		rd_chk(`PLC_A_PAIR_OFF, 8'h0f);
		wr_reg(`PLC_A_REF_OFF, 8'h00);
		wr_reg(`PLC_A_ALARM_DBL, 8'h00);
		chk({5'h0, refoff, dbl}, 8'h00);
	endtask : t_power_down

	// Upper address byte must match too; read data drop after one cycle
	task automatic t_unmapped();
		wr_reg(16'h0169, 8'h01);
		chk({7'h0, manual}, 8'h00);
		rd_chk(16'h0169, 8'h00);
		wr_reg(16'h016c, 8'h05);
		chk({3'h0, pump}, 8'h1f);
		rd_chk(`PLC_A_PUMP, 8'h1f);
		@(posedge clk);
		#1;
		chk(rdata, 8'h00);
	endtask : t_unmapped

	task automatic t_alarm_irq();
		@(posedge clk);
		locked <= 1'b1;
		settle();
		chk({7'h0, alarm}, 8'h00);
		rd_chk(`PLC_A_IRQ_STS, 8'h00);
		wr_reg(`PLC_A_ALARM_DBL, 8'h02);
		settle();
		chk({7'h0, alarm}, 8'h01);
		rd_chk(`PLC_A_IRQ_STS, 8'h01);
		chk({7'h0, irq}, 8'h00);
		wr_reg(`PLC_A_IRQ_MSK, 8'h01);
		chk({7'h0, irq}, 8'h01);
		@(posedge clk);
		stable <= 1'b1;
		settle();
		chk({7'h0, alarm}, 8'h00);
		wr_reg(`PLC_A_IRQ_STS, 8'h00);
		chk({7'h0, irq}, 8'h01);
		wr_reg(`PLC_A_IRQ_STS, 8'h01);
		chk({7'h0, irq}, 8'h00);
		// Lock lost under policy zero raises a fresh event
		wr_reg(`PLC_A_ALARM_DBL, 8'h00);
		@(posedge clk);
		locked <= 1'b0;
		settle();
		chk({6'h0, alarm, irq}, 8'h03);
		rd_chk(`PLC_A_LIVE, 8'h05);
	endtask : t_alarm_irq

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// Hang guard, far beyond the roughly 130 cycles the run needs
	initial
	begin
		#50000;
		fail_count++;
		tally_and_finish();
	end

	initial
	begin
		fail_count = 0;
		compares = 0;
		rst = 1'b1;
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		locked = 1'b0;
		stable = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_reset_values();
		t_manual_lock();
		t_pump();
		t_power_down();
		t_unmapped();
		t_alarm_irq();
		tally_and_finish();
	end
endmodule : plc_top_tb
